// ### hw/rcu_params.svh
// Constants for the rate-control parameter unpacker
`ifndef RCU_PARAMS_SVH
`define RCU_PARAMS_SVH

// ----------------------------------------------------------------------
// Parameter block span
// ----------------------------------------------------------------------
`define RCU_FIRST_BYTE     7'h26
`define RCU_LAST_BYTE      7'h57
`define RCU_GROUP_BYTES    50
`define RCU_GROUP_BITS     400

// ----------------------------------------------------------------------
// Field positions, as byte offsets inside the group
// ----------------------------------------------------------------------
`define RCU_OFS_CAP_HI     0
`define RCU_OFS_CAP_LO     1
`define RCU_OFS_EDGE       2
`define RCU_OFS_THR_A      3
`define RCU_OFS_THR_B      4
`define RCU_OFS_MARGIN     5
`define RCU_OFS_BOUNDS     6
`define RCU_OFS_RANGES     20
`define RCU_NUM_BOUNDS     14
`define RCU_NUM_RANGES     15
`define RCU_BOUND_PAD      6'h00

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define RCU_REG_CTRL       8'h00
`define RCU_REG_STATUS     8'h04
`define RCU_REG_PEEK_SEL   8'h08
`define RCU_REG_PEEK_DATA  8'h0C
`define RCU_REG_SUMMARY    8'h10
`define RCU_CTRL_RESET     2'h1
`define RCU_CTRL_CAPTURE   0
`define RCU_CTRL_CLR_LATE  1

`endif

// ### hw/rcu_pkg.sv
// Types shared by the rate-control parameter unpacker
package rcu_pkg;

    // One byte of the parameter block from the transport
    typedef struct packed {
        logic       valid;
        logic [6:0] index;
        logic [7:0] data;
    } rcu_byte_t;

    // Settings for one buffer fullness range
    typedef struct packed {
        logic [4:0]        range_floor_quant;
        logic [4:0]        range_ceiling_quant;
        logic signed [5:0] budget_adjust;
    } rcu_range_t;

    // Unpacked rate-control group
    typedef struct packed {
        logic [15:0]            buffer_model_capacity;
        logic [3:0]             activity_edge_ratio;
        logic [4:0]             qp_raise_threshold_a;
        logic [4:0]             qp_raise_threshold_b;
        logic [3:0]             target_bits_upper_margin;
        logic [3:0]             target_bits_lower_margin;
        logic [13:0][13:0]      fullness_range_bounds;
        rcu_range_t [14:0]      per_range_settings;
    } rcu_fields_t;

endpackage

// ### hw/rcu_range_unpack.sv
// Splits one 16-bit per-range record into its three fields
`timescale 1ns/1ps
`default_nettype none

module rcu_range_unpack
    import rcu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] record,
    output wire rcu_range_t  settings
);

    // Most significant bits first: floor, ceiling, then adjustment
    assign settings.range_floor_quant   = record[15:11];
    assign settings.range_ceiling_quant = record[10:6];
    assign settings.budget_adjust       = record[5:0];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_record_order;
        @(posedge clk) disable iff (!rst_n)
        {settings.range_floor_quant, settings.range_ceiling_quant,
         settings.budget_adjust} == record;
    endproperty
    a_record_order: assert property (p_record_order)
        else $error("range record fields out of order");

    property p_adjust_sign;
        @(posedge clk) disable iff (!rst_n)
        record[5] |-> (settings.budget_adjust < 0);
    endproperty
    a_adjust_sign: assert property (p_adjust_sign)
        else $error("budget adjustment lost its sign");

endmodule // rcu_range_unpack

`default_nettype wire

// ### hw/rcu_unpacker.sv
// Rate-control parameter unpacker: capture, apply and field decode
//
// Functional notes
// - Parameter bytes 38 to 87, 400 bits, form the decoded rate-control group.
// - Buffer model capacity is a 16-bit unsigned value from bytes 38 and 39.
// - Activity edge ratio is byte 40 bits 3..0, one fractional bit.
// - Two 5-bit QP raise thresholds come from bytes 41 and 42, bits 4..0.
// - Target bits upper margin is byte 43 bits 7..4.
// - Target bits lower margin is byte 43 bits 3..0.
// - Fourteen range bounds from bytes 44..57, each padded with six low zeros.
// - The fourteen bounds split the buffer model into fifteen ranges.
// - Fifteen 16-bit per-range records come from bytes 58 through 87.
// - Each record carries a 5-bit floor QP for its range.
// - Each record carries a 5-bit ceiling QP for its range.
// - Each record carries a 6-bit signed target budget adjustment.
// - Parameters are applied before the picture data they govern arrives; the code applies on param_done and only flags early picture data.
// - Parameter bits never count against a picture or slice bit budget.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcu_params.svh"

module rcu_unpacker
    import rcu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Parameter byte stream from the transport
    input  wire rcu_byte_t   param_byte,
    input  wire logic        param_done,
    // Start of the picture data that the parameters govern
    input  wire logic        picture_start,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Decoded fields towards rate control
    output wire rcu_fields_t rate_control_group,
    output logic             params_ready
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // True when a block byte index falls inside the group
    function automatic logic in_group(input logic [6:0] idx);
        in_group = (idx >= `RCU_FIRST_BYTE) && (idx <= `RCU_LAST_BYTE);
    endfunction

    // Offset of a block byte inside the group
    function automatic logic [5:0] group_ofs(input logic [6:0] idx);
        logic [6:0] d;
        d = idx - `RCU_FIRST_BYTE;
        group_ofs = d[5:0];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [49:0][7:0] shadow_reg;
    logic [49:0][7:0] active_reg;
    logic [1:0]       ctrl_reg;
    logic [5:0]       peek_sel_reg;
    logic             ready_reg;
    logic             late_reg;
    logic             pending_reg;
    logic             capture_ok;
    logic             apply_now;
    logic             clr_late;

    // Byte accepted into the shadow copy; nothing else enters it
    assign capture_ok = param_byte.valid && ctrl_reg[`RCU_CTRL_CAPTURE]
                        && in_group(param_byte.index);
    assign apply_now  = param_done;
    assign clr_late   = reg_wr && (reg_addr == `RCU_REG_CTRL)
                        && reg_wdata[`RCU_CTRL_CLR_LATE];

    // Shadow copy collects the incoming block without disturbing outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_reg <= '0;
        end else if (capture_ok) begin
            shadow_reg[group_ofs(param_byte.index)] <= param_byte.data;
        end
    end

    // Shadow copy becomes active in one step on param_done, whenever that comes; picture_start plays no part
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_reg <= '0;
        end else if (apply_now) begin
            active_reg <= shadow_reg;
        end
    end

    // Ready goes high after the first apply and stays
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
        end else if (apply_now) begin
            ready_reg <= 1'b1;
        end
    end

    // Bytes captured but not yet applied
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_reg <= 1'b0;
        end else if (capture_ok) begin
            pending_reg <= 1'b1;
        end else if (apply_now) begin
            pending_reg <= 1'b0;
        end
    end

    // Picture arriving before any apply is flagged; set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            late_reg <= 1'b0;
        end else if (picture_start && !ready_reg) begin
            late_reg <= 1'b1;
        end else if (clr_late) begin
            late_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Field decode from the active copy
    // ------------------------------------------------------------------

    // Scalar fields; reserved high bits of bytes 40..42 are dropped
    assign rate_control_group.buffer_model_capacity =
        {active_reg[`RCU_OFS_CAP_HI], active_reg[`RCU_OFS_CAP_LO]};
    assign rate_control_group.activity_edge_ratio =
        active_reg[`RCU_OFS_EDGE][3:0];
    assign rate_control_group.qp_raise_threshold_a =
        active_reg[`RCU_OFS_THR_A][4:0];
    assign rate_control_group.qp_raise_threshold_b =
        active_reg[`RCU_OFS_THR_B][4:0];
    assign rate_control_group.target_bits_upper_margin =
        active_reg[`RCU_OFS_MARGIN][7:4];
    assign rate_control_group.target_bits_lower_margin =
        active_reg[`RCU_OFS_MARGIN][3:0];

    // Fourteen bounds, each scaled by six zero bits; they fence 15 ranges
    generate
        for (genvar b = 0; b < `RCU_NUM_BOUNDS; b++) begin : g_bound
            assign rate_control_group.fullness_range_bounds[b] =
                {active_reg[`RCU_OFS_BOUNDS + b], `RCU_BOUND_PAD};
        end
    endgenerate

    // Fifteen two-byte records, high byte first
    generate
        for (genvar r = 0; r < `RCU_NUM_RANGES; r++) begin : g_range
            rcu_range_unpack u_range (
                .clk      (clk),
                .rst_n    (rst_n),
                .record   ({active_reg[`RCU_OFS_RANGES + 2 * r],
                            active_reg[`RCU_OFS_RANGES + 2 * r + 1]}),
                .settings (rate_control_group.per_range_settings[r])
            );
        end
    endgenerate

    // Parameter bytes feed no bit counter: they leave only as fields and through the peek register
    assign params_ready = ready_reg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------

    // Control and peek index written by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg     <= `RCU_CTRL_RESET;
            peek_sel_reg <= 6'h00;
        end else if (reg_wr) begin
            if (reg_addr == `RCU_REG_CTRL) begin
                ctrl_reg <= {1'b0, reg_wdata[`RCU_CTRL_CAPTURE]};
            end
            if (reg_addr == `RCU_REG_PEEK_SEL) begin
                peek_sel_reg <= reg_wdata[5:0];
            end
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `RCU_REG_CTRL:      reg_rdata <= {30'h0, ctrl_reg};
                `RCU_REG_STATUS:    reg_rdata <= {29'h0, pending_reg, late_reg, ready_reg};
                `RCU_REG_PEEK_SEL:  reg_rdata <= {26'h0, peek_sel_reg};
                `RCU_REG_PEEK_DATA: reg_rdata <= (peek_sel_reg < 6'h32)
                                                 ? {24'h0, active_reg[peek_sel_reg]}
                                                 : 32'h0000_0000;
                `RCU_REG_SUMMARY:   reg_rdata <= {16'h0,
                                         rate_control_group.buffer_model_capacity};
                default:            reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_apply;
        apply_now;
    endsequence

    // Span limits spelled out here, though the check also requires !capture_ok, which leans on the decode helper
    sequence s_outside_byte;
        param_byte.valid && ((param_byte.index < `RCU_FIRST_BYTE)
                             || (param_byte.index > `RCU_LAST_BYTE));
    endsequence

    property p_outside_ignored;
        @(posedge clk) disable iff (!rst_n)
        s_outside_byte ##0 !capture_ok |=> $stable(shadow_reg);
    endproperty
    a_outside_ignored: assert property (p_outside_ignored)
        else $error("byte outside the group changed the shadow copy");

    property p_capacity;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> rate_control_group.buffer_model_capacity
                    == {$past(shadow_reg[0]), $past(shadow_reg[1])};
    endproperty
    a_capacity: assert property (p_capacity)
        else $error("buffer model capacity wrong after apply");

    property p_edge;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> rate_control_group.activity_edge_ratio == $past(shadow_reg[2][3:0]);
    endproperty
    a_edge: assert property (p_edge)
        else $error("activity edge ratio wrong after apply");

    property p_thresholds;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> rate_control_group.qp_raise_threshold_a == $past(shadow_reg[3][4:0])
                 && rate_control_group.qp_raise_threshold_b == $past(shadow_reg[4][4:0]);
    endproperty
    a_thresholds: assert property (p_thresholds)
        else $error("QP raise thresholds wrong after apply");

    property p_margins;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> {rate_control_group.target_bits_upper_margin,
                     rate_control_group.target_bits_lower_margin} == $past(shadow_reg[5]);
    endproperty
    a_margins: assert property (p_margins)
        else $error("target margins wrong after apply");

    property p_bound_pad;
        @(posedge clk) disable iff (!rst_n)
        rate_control_group.fullness_range_bounds[13][5:0] == 6'h00
        && rate_control_group.fullness_range_bounds[0][13:6] == active_reg[6];
    endproperty
    a_bound_pad: assert property (p_bound_pad)
        else $error("range bound not scaled by six zero bits");

    property p_last_record;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> rate_control_group.per_range_settings[14]
                    == {$past(shadow_reg[48]), $past(shadow_reg[49])};
    endproperty
    a_last_record: assert property (p_last_record)
        else $error("last range record taken from wrong bytes");

    property p_ready_after_apply;
        @(posedge clk) disable iff (!rst_n)
        s_apply |=> params_ready [*2];
    endproperty
    a_ready_after_apply: assert property (p_ready_after_apply)
        else $error("parameters not ready after apply");

    property p_late_flag;
        @(posedge clk) disable iff (!rst_n)
        picture_start && !params_ready |=> late_reg;
    endproperty
    a_late_flag: assert property (p_late_flag)
        else $error("early picture not flagged");

    property p_capture_off;
        @(posedge clk) disable iff (!rst_n)
        !ctrl_reg[`RCU_CTRL_CAPTURE] |=> $stable(shadow_reg);
    endproperty
    a_capture_off: assert property (p_capture_off)
        else $error("shadow copy changed while capture disabled");

endmodule // rcu_unpacker

`default_nettype wire

// ### sim/rcu_transport_model.sv
// Transport model that delivers the parameter block to the unpacker
`timescale 1ns/1ps
`default_nettype none

module rcu_transport_model
    import rcu_pkg::*;
(
    input  wire logic clk,
    output rcu_byte_t param_byte,
    output logic      param_done,
    output logic      picture_start
);
    // ------------------------------------------------------------------
    // Block contents, loaded by the bench
    // ------------------------------------------------------------------
    logic [7:0] block_mem [0:127];

    // Idle levels at time zero
    initial begin
        param_byte    = '0;
        param_done    = 1'b0;
        picture_start = 1'b0;
    end

    // ------------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------------
    // One picture start pulse, on its own
    task automatic pulse_start();
        @(posedge clk);
        picture_start <= 1'b1;
        @(posedge clk);
        picture_start <= 1'b0;
    endtask

    // One stray byte with no apply after it
    task automatic send_byte(input logic [6:0] idx, input logic [7:0] data);
        @(posedge clk);
        param_byte <= '{1'b1, idx, data};
        @(posedge clk);
        param_byte <= '{1'b0, ~idx, ~data};
    endtask

    // Whole block back to back, unaltered, then apply, then picture data
    task automatic send_block();
        for (int i = 0; i < 128; i++) begin
            @(posedge clk);
            param_byte <= '{1'b1, 7'(i), block_mem[i]};
        end
        @(posedge clk);
        // Released lines carry the inverse so stale data cannot pass
        param_byte <= '{1'b0, ~param_byte.index, ~param_byte.data};
        param_done <= 1'b1;
        @(posedge clk);
        param_done    <= 1'b0;
        picture_start <= 1'b1;
        @(posedge clk);
        picture_start <= 1'b0;
    endtask
endmodule // rcu_transport_model

`default_nettype wire

// ### sim/rcu_unpacker_bench.sv
// Self-checking bench for the rate-control parameter unpacker
`timescale 1ns/1ps
`default_nettype none
`include "rcu_params.svh"

module rcu_unpacker_bench
    import rcu_pkg::*;
;
    logic        clk;
    logic        rst_n;
    rcu_byte_t   param_byte;
    logic        param_done;
    logic        picture_start;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    rcu_fields_t rate_control_group;
    logic        params_ready;
    int          err_count;
    int          total_checks;
    logic [7:0]  exp_mem [0:127];

    // ------------------------------------------------------------------
    // Design and transport
    // ------------------------------------------------------------------
    rcu_unpacker DUT (
        .clk                (clk),
        .rst_n              (rst_n),
        .param_byte         (param_byte),
        .param_done         (param_done),
        .picture_start      (picture_start),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .rate_control_group (rate_control_group),
        .params_ready       (params_ready)
    );

    rcu_transport_model xport (
        .clk           (clk),
        .param_byte    (param_byte),
        .param_done    (param_done),
        .picture_start (picture_start)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_check(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp, "register read");
    endtask

    // Load the same pattern into the transport and the expectation
    task automatic fill(input int seed);
        for (int i = 0; i < 128; i++) begin
            exp_mem[i] = 8'(i * 37 + seed);
        end
        exp_mem[40] = 8'hF5;
        exp_mem[41] = 8'hEA;
        exp_mem[42] = 8'hB3;
        for (int i = 0; i < 128; i++) begin
            xport.block_mem[i] = exp_mem[i];
        end
    endtask

    task automatic check_fields();
        logic [15:0] rec;
        rcu_fields_t g;
        g = rate_control_group;
        check(32'(g.buffer_model_capacity), {16'h0, exp_mem[38], exp_mem[39]}, "capacity");
        check(32'(g.activity_edge_ratio), {28'h0, exp_mem[40][3:0]}, "edge");
        check(32'(g.qp_raise_threshold_a), {27'h0, exp_mem[41][4:0]}, "thr a");
        check(32'(g.qp_raise_threshold_b), {27'h0, exp_mem[42][4:0]}, "thr b");
        check(32'(g.target_bits_upper_margin), {28'h0, exp_mem[43][7:4]}, "upper");
        check(32'(g.target_bits_lower_margin), {28'h0, exp_mem[43][3:0]}, "lower");
        for (int k = 0; k < 14; k++) begin
            check(32'(g.fullness_range_bounds[k]), {18'h0, exp_mem[44+k], 6'h00}, "bound");
        end
        for (int k = 0; k < 15; k++) begin
            rec = {exp_mem[58+2*k], exp_mem[59+2*k]};
            check(32'(g.per_range_settings[k].range_floor_quant), {27'h0, rec[15:11]}, "floor");
            check(32'(g.per_range_settings[k].range_ceiling_quant), {27'h0, rec[10:6]}, "ceil");
            check(32'(g.per_range_settings[k].budget_adjust), {{26{rec[5]}}, rec[5:0]}, "adjust");
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state and an unmapped read
        check(32'(params_ready), 32'h0, "ready after reset");
        check(32'(rate_control_group.buffer_model_capacity), 32'h0, "capacity after reset");
        reg_check(`RCU_REG_CTRL, 32'h1);
        reg_check(`RCU_REG_STATUS, 32'h0);
        reg_check(`RCU_REG_PEEK_SEL, 32'h0);
        reg_check(`RCU_REG_SUMMARY, 32'h0);
        reg_check(8'h14, 32'h0);
        // Picture data before any apply is flagged late, then cleared
        xport.pulse_start();
        reg_check(`RCU_REG_STATUS, 32'h2);
        reg_write(`RCU_REG_CTRL, 32'h3);
        reg_check(`RCU_REG_STATUS, 32'h0);
        // Full block applied ahead of the picture data
        fill(5);
        xport.send_block();
        reg_check(`RCU_REG_STATUS, 32'h1);
        check(32'(params_ready), 32'h1, "ready after apply");
        check_fields();
        reg_check(`RCU_REG_SUMMARY, {16'h0, exp_mem[38], exp_mem[39]});
        // Peek at byte 40, the last and one past the last stored byte
        reg_write(`RCU_REG_PEEK_SEL, 32'h2);
        reg_check(`RCU_REG_PEEK_DATA, {24'h0, exp_mem[40]});
        reg_write(`RCU_REG_PEEK_SEL, 32'h31);
        reg_check(`RCU_REG_PEEK_DATA, {24'h0, exp_mem[87]});
        reg_write(`RCU_REG_PEEK_SEL, 32'h32);
        reg_check(`RCU_REG_PEEK_SEL, 32'h32);
        reg_check(`RCU_REG_PEEK_DATA, 32'h0);
        // A byte past the group leaves pending clear; one inside sets it
        xport.send_byte(7'h58, 8'h5A);
        reg_check(`RCU_REG_STATUS, 32'h1);
        xport.send_byte(7'h26, exp_mem[38]);
        reg_check(`RCU_REG_STATUS, 32'h5);
        // Capture disabled: a new block leaves the fields untouched
        reg_write(`RCU_REG_CTRL, 32'h0);
        reg_check(`RCU_REG_CTRL, 32'h0);
        for (int i = 0; i < 128; i++) begin
            xport.block_mem[i] = ~exp_mem[i];
        end
        xport.send_block();
        check_fields();
        reg_check(`RCU_REG_STATUS, 32'h1);
        // Capture back on with a second pattern
        reg_write(`RCU_REG_CTRL, 32'h1);
        fill(91);
        xport.send_block();
        check_fields();
        print_verdict();
    end

    // Watchdog well beyond the roughly 500 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule // rcu_unpacker_bench

`default_nettype wire
